// ### hdl/mcuid_pkg.sv
// constants, types and decode helpers for the instruction decode and timing block
package mcuid_pkg;
  localparam int WORD_W  = 24;
  localparam int OPC_W   = 8;
  localparam int OPC_LSB = 16;
  localparam int HALF_W  = 16;
  localparam int REG_W   = 4;
  localparam int MODE_W  = 2;
  localparam int FADDR_W = 13;
  localparam int LIT_W   = 12;
  localparam int CYC_W   = 2;
  localparam logic [FADDR_W-1:0] FILE_ADDR_MAX = 13'h1fff;
  localparam logic [OPC_W-1:0]   OPC_NONE      = 8'h00;
  // operand field positions inside the low 16 bits
  localparam int F_BASE  = 12;
  localparam int F_DEST  = 8;
  localparam int F_DMODE = 6;
  localparam int F_SMODE = 4;
  localparam int F_SRC   = 0;
  localparam int F_FADDR = 0;
  localparam int F_FDSEL = 13;
  localparam int F_BITLO = 13;
  localparam int F_KMOVE = 4;
  localparam int F_KARI  = 4;
  localparam int F_TMODE = 0;
  // opcode bits: group, subtype, form flags
  localparam int O_GRP   = 6;
  localparam int O_SUB   = 3;
  localparam int O_ARITH = 3;
  localparam int O_FILE  = 2;
  localparam int O_IND   = 1;
  localparam logic [1:0] GRP_CTRL = 2'h0;
  localparam logic [1:0] GRP_WB   = 2'h1;
  localparam logic [1:0] GRP_BIT  = 2'h2;
  localparam logic [1:0] GRP_LIT  = 2'h3;
  localparam logic [2:0] CT_BRA   = 3'h1;
  localparam logic [2:0] CT_IND   = 3'h2;
  localparam logic [2:0] CT_TBL   = 3'h3;
  localparam logic [2:0] CT_RET   = 3'h4;
  localparam logic [2:0] CT_RETI  = 3'h5;
  localparam logic [2:0] CT_DBL   = 3'h6;
  localparam logic [2:0] CT_SKIP  = 3'h7;
  localparam logic [2:0] WB_DMOV  = 3'h7;
  // added no-operation cycles per case, then the total cycle count of a double-word
  localparam logic [CYC_W-1:0] XC_NONE = 2'h0;
  localparam logic [CYC_W-1:0] XC_ONE  = 2'h1;
  localparam logic [CYC_W-1:0] XC_TWO  = 2'h2;
  localparam logic [CYC_W-1:0] CYC_DBL = 2'h2;
  typedef enum logic [2:0] {
    ST_FETCH  = 3'h1,
    ST_SECOND = 3'h2,
    ST_NOP    = 3'h4
  } mcuid_state_t;
  function automatic logic mcuid_is_two_word(input logic [OPC_W-1:0] opc);
    logic [1:0] grp;
    logic [2:0] sub;
    grp = opc[O_GRP +: 2];
    sub = opc[O_SUB +: 3];
    return (grp == GRP_CTRL && sub == CT_DBL) || (grp == GRP_WB && sub == WB_DMOV);
  endfunction
endpackage

// ### hdl/mcuid_field_split.sv
// operand field extraction from one program word
`timescale 1ns/10ps
module mcuid_field_split
  import mcuid_pkg::*;
(
  input  wire logic [WORD_W-1:0]  word_in,
  output logic      [REG_W-1:0]   base_reg_out,
  output logic      [REG_W-1:0]   src_reg_out,
  output logic      [MODE_W-1:0]  src_mode_out,
  output logic      [REG_W-1:0]   dest_reg_out,
  output logic      [MODE_W-1:0]  dest_mode_out,
  output logic      [FADDR_W-1:0] file_addr_out,
  output logic                    dest_is_file_out,
  output logic      [REG_W-1:0]   bit_pos_out,
  output logic                    bit_indirect_out,
  output logic      [LIT_W-1:0]   literal_out,
  output logic      [MODE_W-1:0]  table_mode_out
);
  wire [OPC_W-1:0] opc      = word_in[OPC_LSB +: OPC_W];
  wire [1:0]       grp      = opc[O_GRP +: 2];
  wire             file_frm = opc[O_FILE];
  wire [REG_W-1:0] base     = word_in[F_BASE +: REG_W];

  assign base_reg_out     = base;
  assign src_reg_out      = word_in[F_SRC +: REG_W];
  assign src_mode_out     = word_in[F_SMODE +: MODE_W];
  assign dest_mode_out    = word_in[F_DMODE +: MODE_W];
  // literal arithmetic without its own destination writes back to base
  assign dest_reg_out     = (grp == GRP_LIT && opc[O_ARITH] && !file_frm) ? base :
                            word_in[F_DEST +: REG_W];
  assign file_addr_out    = word_in[F_FADDR +: FADDR_W];
  assign dest_is_file_out = word_in[F_FDSEL];
  // file form has no room for a 4-bit bit position, so its top bit rides in the opcode
  assign bit_pos_out      = file_frm ? {opc[0], word_in[F_BITLO +: 3]} : base;
  assign bit_indirect_out = (grp == GRP_BIT) && opc[O_IND];
  assign literal_out      = !opc[O_ARITH] ? word_in[F_KMOVE +: LIT_W] :
                            {4'h0, word_in[F_KARI +: 8]};
  assign table_mode_out   = word_in[F_TMODE +: MODE_W];
endmodule

// ### hdl/mcuid_cycle_ctr.sv
// down-counter for added no-operation cycles
`timescale 1ns/10ps
module mcuid_cycle_ctr
  import mcuid_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             load_in,
  input  wire logic [CYC_W-1:0] count_in,
  output logic                  last_out
);
  logic [CYC_W-1:0] left;
  wire  [CYC_W-1:0] next_left = load_in ? count_in :
                                (left != XC_NONE) ? left - XC_ONE : XC_NONE;
  assign last_out = (left == XC_ONE);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left <= XC_NONE;
    end else begin
      left <= next_left;
    end
  end
endmodule

// ### hdl/mcuid_decode.sv
// instruction decode and cycle-count control top
`timescale 1ns/10ps
module mcuid_decode
  import mcuid_pkg::*;
(
  input  wire logic               ref_clk_in,
  input  wire logic               resetn_in,
  input  wire logic               word_valid_in,
  input  wire logic [WORD_W-1:0]  prog_word_in,
  input  wire logic               cond_true_in,
  input  wire logic               skip_two_word_in,
  output logic                    fetch_ready_out,
  output logic                    instr_valid_out,
  output logic                    commit_out,
  output logic                    nop_cycle_out,
  output logic                    cycle_out,
  output logic      [3:0]         group_out,
  output logic      [CYC_W-1:0]   cycles_out,
  output logic                    two_word_out,
  output logic                    bad_second_out,
  output logic      [OPC_W-1:0]   opcode_out,
  output logic      [REG_W-1:0]   base_source_reg_out,
  output logic      [REG_W-1:0]   second_source_reg_out,
  output logic      [MODE_W-1:0]  second_mode_out,
  output logic      [REG_W-1:0]   dest_reg_out,
  output logic      [MODE_W-1:0]  dest_mode_out,
  output logic      [FADDR_W-1:0] file_addr_out,
  output logic                    dest_is_file_out,
  output logic      [REG_W-1:0]   bit_pos_out,
  output logic                    bit_indirect_out,
  output logic      [LIT_W-1:0]   literal_out,
  output logic      [MODE_W-1:0]  table_mode_out,
  output logic      [HALF_W-1:0]  prog_addr_out,
  output logic      [HALF_W-1:0]  second_word_out
);
  logic              rst_meta;
  logic              rst_n;
  mcuid_state_t      state;
  mcuid_state_t      next_state;
  logic [WORD_W-1:0] first_word;

  // reset released through two flops
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  wire              in_fetch  = (state == ST_FETCH);
  wire              in_second = (state == ST_SECOND);
  wire              in_nop    = (state == ST_NOP);
  wire              take      = word_valid_in && fetch_ready_out;
  wire [OPC_W-1:0]  opc       = prog_word_in[OPC_LSB +: OPC_W];
  wire [1:0]        grp       = opc[O_GRP +: 2];
  wire [2:0]        sub       = opc[O_SUB +: 3];
  wire              is_dbl    = mcuid_is_two_word(opc);
  // a lone second word has a zero opcode and so lands here as a nop
  wire              orphan    = (opc == OPC_NONE);
  wire              take_one  = take && in_fetch && !is_dbl;
  wire              take_dbl1 = take && in_fetch && is_dbl;
  wire              take_dbl2 = take && in_second;
  wire              issue     = take_one || take_dbl2;
  wire              ctrl      = (grp == GRP_CTRL);
  wire              ctr_last;

  // added cycles for a single-word instruction
  wire [CYC_W-1:0] xc_skip = !cond_true_in ? XC_NONE :
                             skip_two_word_in ? XC_TWO : XC_ONE;
  wire [CYC_W-1:0] xc_ctrl =
      (sub == CT_BRA || sub == CT_IND || sub == CT_TBL) ? XC_ONE :
      (sub == CT_RET || sub == CT_RETI) ? XC_TWO :
      (sub == CT_SKIP) ? xc_skip :
      cond_true_in ? XC_ONE : XC_NONE;
  wire [CYC_W-1:0] xc = orphan ? XC_NONE :
                        ctrl ? xc_ctrl :
                        cond_true_in ? XC_ONE : XC_NONE;
  wire             go_nop     = take_one && (xc != XC_NONE);
  wire [CYC_W-1:0] next_cycles = take_dbl2 ? CYC_DBL : CYC_W'(xc + XC_ONE);

  // fields come from the held first word when the pair completes
  wire [WORD_W-1:0] dec_word = in_second ? first_word : prog_word_in;
  wire [OPC_W-1:0]  dec_opc  = dec_word[OPC_LSB +: OPC_W];
  wire [1:0]        dec_grp  = dec_opc[O_GRP +: 2];
  wire [3:0]        dec_oh   = 4'h1 << dec_grp;
  wire              dec_nop  = take_one && orphan;
  wire [HALF_W-1:0] word_low = prog_word_in[HALF_W-1:0];

  wire [REG_W-1:0]   f_base;
  wire [REG_W-1:0]   f_src;
  wire [MODE_W-1:0]  f_smode;
  wire [REG_W-1:0]   f_dest;
  wire [MODE_W-1:0]  f_dmode;
  wire [FADDR_W-1:0] f_faddr;
  wire               f_dfile;
  wire [REG_W-1:0]   f_bit;
  wire               f_bind;
  wire [LIT_W-1:0]   f_lit;
  wire [MODE_W-1:0]  f_tmode;

  mcuid_field_split u_split (
    .word_in          (dec_word),
    .base_reg_out     (f_base),
    .src_reg_out      (f_src),
    .src_mode_out     (f_smode),
    .dest_reg_out     (f_dest),
    .dest_mode_out    (f_dmode),
    .file_addr_out    (f_faddr),
    .dest_is_file_out (f_dfile),
    .bit_pos_out      (f_bit),
    .bit_indirect_out (f_bind),
    .literal_out      (f_lit),
    .table_mode_out   (f_tmode)
  );

  mcuid_cycle_ctr u_ctr (
    .clk_in   (ref_clk_in),
    .rst_n_in (rst_n),
    .load_in  (go_nop),
    .count_in (xc),
    .last_out (ctr_last)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ST_FETCH: begin
        if (take_dbl1) begin
          next_state = ST_SECOND;
        end else if (go_nop) begin
          next_state = ST_NOP;
        end
      end
      ST_SECOND: begin
        if (take) begin
          next_state = ST_FETCH;
        end
      end
      ST_NOP: begin
        if (ctr_last) begin
          next_state = ST_FETCH;
        end
      end
      default: begin
        next_state = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_FETCH;
      first_word <= '0;
    end else begin
      state <= next_state;
      if (take_dbl1) begin
        first_word <= prog_word_in;
      end
    end
  end

  // handshake and timing outputs
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ready_out <= 1'b0;
      instr_valid_out <= 1'b0;
      commit_out      <= 1'b0;
      nop_cycle_out   <= 1'b0;
      cycle_out       <= 1'b0;
      cycles_out      <= XC_NONE;
      two_word_out    <= 1'b0;
      bad_second_out  <= 1'b0;
    end else begin
      fetch_ready_out <= (next_state != ST_NOP);
      instr_valid_out <= issue;
      // nops, lone second words and added cycles never write or touch flags
      commit_out      <= issue && !dec_nop;
      nop_cycle_out   <= in_nop;
      cycle_out       <= take || in_nop;
      two_word_out    <= take_dbl2;
      bad_second_out  <= take_dbl2 && (opc != OPC_NONE);
      if (issue) begin
        cycles_out <= next_cycles;
      end
    end
  end

  // decoded fields, held until the next issue
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      group_out             <= '0;
      opcode_out            <= '0;
      base_source_reg_out   <= '0;
      second_source_reg_out <= '0;
      second_mode_out       <= '0;
      dest_reg_out          <= '0;
      dest_mode_out         <= '0;
      file_addr_out         <= '0;
      dest_is_file_out      <= 1'b0;
      bit_pos_out           <= '0;
      bit_indirect_out      <= 1'b0;
      literal_out           <= '0;
      table_mode_out        <= '0;
      prog_addr_out         <= '0;
      second_word_out       <= '0;
    end else if (issue) begin
      group_out             <= dec_oh;
      opcode_out            <= dec_opc;
      base_source_reg_out   <= f_base;
      second_source_reg_out <= f_src;
      second_mode_out       <= f_smode;
      dest_reg_out          <= f_dest;
      dest_mode_out         <= f_dmode;
      file_addr_out         <= f_faddr;
      dest_is_file_out      <= f_dfile;
      bit_pos_out           <= f_bit;
      bit_indirect_out      <= f_bind;
      literal_out           <= f_lit;
      table_mode_out        <= f_tmode;
      prog_addr_out         <= dec_word[HALF_W-1:0];
      second_word_out       <= take_dbl2 ? prog_word_in[HALF_W-1:0] : '0;
    end
  end

  // three nop cycles in a row would mean the counter missed its last step
  logic [CYC_W-1:0] nop_run;
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      nop_run <= XC_NONE;
    end else begin
      nop_run <= nop_cycle_out ? CYC_W'(nop_run + XC_ONE) : XC_NONE;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  a_nop_no_commit: assert property (nop_cycle_out |-> !commit_out && !instr_valid_out)
    else $error("commit during added nop cycle");
  a_lone_second: assert property (take_one && orphan |=> instr_valid_out && !commit_out)
    else $error("lone second word was not a nop");
  a_second_upper: assert property (take_dbl2 && opc != OPC_NONE |=> bad_second_out)
    else $error("nonzero second word top not flagged");
  // the first word of a pair is only held; the pair issues when the second word lands
  a_dbl_hold: assert property (take_dbl1 |=> !instr_valid_out && fetch_ready_out)
    else $error("first word of a pair issued alone");
  a_dbl_issue: assert property (take_dbl2 |=>
    instr_valid_out && two_word_out && cycles_out == CYC_DBL)
    else $error("double-word not issued with two cycles");
  a_dbl_bits: assert property (take_dbl2 |=> second_word_out == $past(word_low))
    else $error("second word bits lost");
  a_branch_cycles: assert property (take_one && ctrl && sub == CT_BRA |=>
                                    cycles_out == 2'h2 ##1 nop_cycle_out ##1 !nop_cycle_out)
    else $error("branch not two cycles");
  a_return_cycles: assert property (take_one && ctrl && sub == CT_RET |=>
                                    cycles_out == 2'h3 ##1 nop_cycle_out [*2] ##1 !nop_cycle_out)
    else $error("return not three cycles");

  // indirect and table forms share the branch timing
  a_ind_cycles: assert property (take_one && ctrl && (sub == CT_IND || sub == CT_TBL) |=>
    cycles_out == CYC_DBL ##1 nop_cycle_out ##1 !nop_cycle_out)
    else $error("indirect or table op not two cycles");
  a_reti_cycles: assert property (take_one && ctrl && sub == CT_RETI |=>
    cycles_out == 2'h3 ##1 nop_cycle_out [*2] ##1 !nop_cycle_out)
    else $error("interrupt return not three cycles");
  a_skip_double: assert property (take_one && ctrl && sub == CT_SKIP && cond_true_in &&
                                  skip_two_word_in |=> cycles_out == 2'h3)
    else $error("skip over double word not three cycles");

  a_skip_single: assert property (take_one && ctrl && sub == CT_SKIP && cond_true_in &&
    !skip_two_word_in |=> cycles_out == CYC_DBL)
    else $error("skip over single word not two cycles");
  a_skip_none: assert property (take_one && ctrl && sub == CT_SKIP && !cond_true_in |=>
    cycles_out == 2'h1)
    else $error("untaken skip took extra cycle");
  a_single_one: assert property (take_one && xc == XC_NONE |=>
                                 cycles_out == 2'h1 && fetch_ready_out ##1 !nop_cycle_out)
    else $error("plain instruction took extra cycle");
  a_cond_two: assert property (take_one && !ctrl && !orphan && cond_true_in |=>
                               cycles_out == 2'h2)
    else $error("true test not two cycles");
  a_group_onehot: assert property (instr_valid_out |-> $onehot(group_out))
    else $error("group not one-hot");

  // words offered while added cycles remain must be refused
  a_ready_refused: assert property (in_nop && !ctr_last |=> !fetch_ready_out)
    else $error("word accepted during added cycle");
  a_nop_run: assert property (nop_run != 2'h3)
    else $error("more than two added cycles in a row");
  a_nop_counted: assert property (nop_cycle_out |-> cycle_out)
    else $error("added cycle not counted as a cycle");

  // covers mark the main timing cases
  c_branch: cover property (take_one && ctrl && sub == CT_BRA);
  c_return: cover property (take_one && ctrl && sub == CT_RET);
  c_skip_two: cover property (take_one && ctrl && sub == CT_SKIP && cond_true_in &&
                              skip_two_word_in);
  c_double: cover property (take_dbl2);
  c_lone: cover property (take_one && orphan);
endmodule

// ### test/mcuid_prog_mem.sv
// program memory fetch model: offers one word and holds it until the decoder takes it
`timescale 1ns/10ps
module mcuid_prog_mem
  import mcuid_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              req_in,
  input  wire logic [WORD_W-1:0] word_in,
  input  wire logic              cond_in,
  input  wire logic              skip2_in,
  input  wire logic              ready_in,
  output logic                   word_valid_out,
  output logic      [WORD_W-1:0] prog_word_out,
  output logic                   cond_true_out,
  output logic                   skip_two_word_out,
  output logic                   taken_out
);
  wire logic take = word_valid_out && ready_in;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_valid_out    <= 1'b0;
      prog_word_out     <= 24'h00_0000;
      cond_true_out     <= 1'b0;
      skip_two_word_out <= 1'b0;
      taken_out         <= 1'b0;
    end else begin
      taken_out <= take;
      if (take || !word_valid_out) begin
        // a released word is scrambled so a stale value can never pass as a new one
        word_valid_out    <= req_in;
        prog_word_out     <= req_in ? word_in : ~prog_word_out;
        cond_true_out     <= req_in ? cond_in : ~cond_true_out;
        skip_two_word_out <= req_in ? skip2_in : ~skip_two_word_out;
      end
    end
  end
endmodule

// ### test/tb_top.sv
// self-checking bench for the instruction decode and timing block
`timescale 1ns/10ps
module tb_top
  import mcuid_pkg::*;
;
  typedef struct {
    logic [23:0] w1;
    logic [23:0] w2;
    logic        dbl;
    logic        cond;
    logic        skip2;
    logic [3:0]  grp;
    logic [1:0]  cyc;
    logic        commit;
    logic        bad;
  } mcuid_row_t;
  logic        ref_clk_in, resetn_in, req, cond, skip2, word_valid, cond_true, skip_two_word;
  logic        taken, fetch_ready, instr_valid, commit, nop_cycle, cyc_p, two_word;
  logic        bad_second, dest_is_file, bit_ind;
  logic [3:0]  group, base_r, src_r, dest_r, bit_pos;
  logic [1:0]  cycles, smode, dmode, tmode;
  logic [7:0]  opcode;
  logic [12:0] file_addr;
  logic [11:0] literal;
  logic [15:0] prog_addr, second_w;
  logic [23:0] word, prog_word;
  int          n_fail, num_checks, ticks;
  mcuid_row_t  rows [16];

  mcuid_prog_mem mcuid_prog_mem_inst (.clk_in(ref_clk_in), .rst_n_in(resetn_in), .req_in(req),
    .word_in(word), .cond_in(cond), .skip2_in(skip2), .ready_in(fetch_ready),
    .word_valid_out(word_valid), .prog_word_out(prog_word), .cond_true_out(cond_true),
    .skip_two_word_out(skip_two_word), .taken_out(taken));

  mcuid_decode mcuid_decode_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .word_valid_in(word_valid), .prog_word_in(prog_word), .cond_true_in(cond_true),
    .skip_two_word_in(skip_two_word), .fetch_ready_out(fetch_ready),
    .instr_valid_out(instr_valid), .commit_out(commit), .nop_cycle_out(nop_cycle),
    .cycle_out(cyc_p), .group_out(group), .cycles_out(cycles), .two_word_out(two_word),
    .bad_second_out(bad_second), .opcode_out(opcode), .base_source_reg_out(base_r),
    .second_source_reg_out(src_r), .second_mode_out(smode), .dest_reg_out(dest_r),
    .dest_mode_out(dmode), .file_addr_out(file_addr), .dest_is_file_out(dest_is_file),
    .bit_pos_out(bit_pos), .bit_indirect_out(bit_ind), .literal_out(literal),
    .table_mode_out(tmode), .prog_addr_out(prog_addr), .second_word_out(second_w));

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    @(posedge ref_clk_in);
    resetn_in <= 1'b0;
    repeat (12) @(posedge ref_clk_in);
    chk("reset ready", 24'(fetch_ready), 24'h0);
    chk("reset issue", 24'(instr_valid), 24'h0);
    chk("reset group", 24'(group), 24'h0);
    resetn_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk("ready early", 24'(fetch_ready), 24'h0);
    @(negedge ref_clk_in);
    chk("ready late", 24'(fetch_ready), 24'h1);
    $display("reset test done");
  endtask

  task automatic send(input logic [23:0] w, input logic c, input logic s);
    int k;
    k = 0;
    @(posedge ref_clk_in);
    req <= 1'b1;
    word <= w;
    cond <= c;
    skip2 <= s;
    @(posedge ref_clk_in);
    req <= 1'b0;
    do begin
      @(negedge ref_clk_in);
      k++;
    end while (taken !== 1'b1 && k < 40);
    chk("taken", 24'(taken), 24'h1);
  endtask

  task automatic run(input mcuid_row_t r);
    int nops;
    int lows;
    int ncyc;
    int bad_nop;
    int extra;
    nops = 0;
    lows = 0;
    ncyc = 0;
    bad_nop = 0;
    extra = r.dbl ? 0 : int'(r.cyc) - 1;
    send(r.w1, r.cond, r.skip2);
    if (r.dbl) begin
      chk("early issue", 24'(instr_valid), 24'h0);
      chk("first cycle", 24'(cyc_p), 24'h1);
      send(r.w2, 1'b0, 1'b0);
      chk("second", 24'(second_w), 24'(r.w2[15:0]));
    end
    chk("issue", 24'(instr_valid), 24'h1);
    chk("opcode", 24'(opcode), 24'(r.w1[23:16]));
    chk("group", 24'(group), 24'(r.grp));
    chk("cycles", 24'(cycles), 24'(r.cyc));
    chk("commit", 24'(commit), 24'(r.commit));
    chk("two word", 24'(two_word), 24'(r.dbl));
    chk("bad second", 24'(bad_second), 24'(r.bad));
    chk("address", 24'(prog_addr), 24'(r.w1[15:0]));
    for (int k = 0; k < 4; k++) begin
      if (k < 3 && fetch_ready !== 1'b1) lows++;
      if (k > 0 && nop_cycle === 1'b1) nops++;
      if (nop_cycle === 1'b1 && commit !== 1'b0) bad_nop++;
      if (cyc_p === 1'b1) ncyc++;
      @(negedge ref_clk_in);
    end
    chk("added nops", 24'(nops), 24'(extra));
    chk("ready low", 24'(lows), 24'(extra));
    chk("nop commit", 24'(bad_nop), 24'h0);
    chk("cycle pulses", 24'(ncyc), r.dbl ? 24'h1 : 24'(r.cyc));
  endtask

  // plain register, file, bit and literal forms take one cycle
  task automatic one(input logic [23:0] w, input logic [3:0] g);
    run('{w, 24'h0, 1'b0, 1'b0, 1'b0, g, 2'h1, 1'b1, 1'b0});
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    ticks++;
    if (ticks == 3000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    int k;
    resetn_in = 1'b0;
    req = 1'b0;
    word = 24'h00_0000;
    cond = 1'b0;
    skip2 = 1'b0;
    rows = '{
      '{24'h40_0000, 24'h0, 1'b0, 1'b0, 1'b0, 4'h2, 2'h1, 1'b1, 1'b0},
      '{24'h40_0000, 24'h0, 1'b0, 1'b1, 1'b0, 4'h2, 2'h2, 1'b1, 1'b0},
      '{24'h80_0000, 24'h0, 1'b0, 1'b0, 1'b0, 4'h4, 2'h1, 1'b1, 1'b0},
      '{24'hc0_0000, 24'h0, 1'b0, 1'b0, 1'b0, 4'h8, 2'h1, 1'b1, 1'b0},
      '{24'h08_1234, 24'h0, 1'b0, 1'b0, 1'b0, 4'h1, 2'h2, 1'b1, 1'b0},
      '{24'h10_0000, 24'h0, 1'b0, 1'b0, 1'b0, 4'h1, 2'h2, 1'b1, 1'b0},
      '{24'h18_0003, 24'h0, 1'b0, 1'b0, 1'b0, 4'h1, 2'h2, 1'b1, 1'b0},
      '{24'h20_0000, 24'h0, 1'b0, 1'b0, 1'b0, 4'h1, 2'h3, 1'b1, 1'b0},
      '{24'h28_0000, 24'h0, 1'b0, 1'b0, 1'b0, 4'h1, 2'h3, 1'b1, 1'b0},
      '{24'h38_0000, 24'h0, 1'b0, 1'b0, 1'b0, 4'h1, 2'h1, 1'b1, 1'b0},
      '{24'h38_0000, 24'h0, 1'b0, 1'b1, 1'b0, 4'h1, 2'h2, 1'b1, 1'b0},
      '{24'h38_0000, 24'h0, 1'b0, 1'b1, 1'b1, 4'h1, 2'h3, 1'b1, 1'b0},
      '{24'h00_5555, 24'h0, 1'b0, 1'b0, 1'b0, 4'h1, 2'h1, 1'b0, 1'b0},
      '{24'h30_8000, 24'h00_1234, 1'b1, 1'b0, 1'b0, 4'h1, 2'h2, 1'b1, 1'b0},
      '{24'h78_0001, 24'h00_abcd, 1'b1, 1'b0, 1'b0, 4'h2, 2'h2, 1'b1, 1'b0},
      '{24'h30_0000, 24'h5a_0000, 1'b1, 1'b0, 1'b0, 4'h1, 2'h2, 1'b1, 1'b1}};
    do_reset();
    foreach (rows[i]) begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    // a word offered while added cycles run must wait for them
    @(posedge ref_clk_in);
    req <= 1'b1;
    word <= 24'h20_0000;
    @(posedge ref_clk_in);
    word <= 24'h40_0000;
    @(posedge ref_clk_in);
    req <= 1'b0;
    k = 0;
    do begin
      @(negedge ref_clk_in);
      k++;
    end while (instr_valid !== 1'b1 && k < 20);
    chk("first issue", 24'(instr_valid), 24'h1);
    k = 0;
    do begin
      @(negedge ref_clk_in);
      k++;
    end while (instr_valid !== 1'b1 && k < 20);
    chk("refused gap", 24'(k), 24'h3);
    $display("back to back test done");
    do_reset();
    one(24'h40_5a9c, 4'h2);
    chk("base", 24'(base_r), 24'h5);
    chk("source", 24'(src_r), 24'hc);
    chk("source mode", 24'(smode), 24'h1);
    chk("dest", 24'(dest_r), 24'ha);
    chk("dest mode", 24'(dmode), 24'h2);
    one(24'h44_3fff, 4'h2);
    chk("file addr", 24'(file_addr), 24'h1fff);
    chk("to file", 24'(dest_is_file), 24'h1);
    one(24'h44_1fff, 4'h2);
    chk("to work zero", 24'(dest_is_file), 24'h0);
    one(24'h85_e000, 4'h4);
    chk("bit pos", 24'(bit_pos), 24'hf);
    one(24'h82_0000, 4'h4);
    chk("bit indirect", 24'(bit_ind), 24'h1);
    one(24'hc0_abc0, 4'h8);
    chk("move literal", 24'(literal), 24'habc);
    one(24'hc8_7a50, 4'h8);
    chk("arith literal", 24'(literal), 24'h0a5);
    chk("arith dest", 24'(dest_r), 24'h7);
    run('{24'h18_0002, 24'h0, 1'b0, 1'b0, 1'b0, 4'h1, 2'h2, 1'b1, 1'b0});
    chk("table mode", 24'(tmode), 24'h2);
    $display("field tests done");
    close_out();
  end
endmodule
